// ==== design/ddr_dll_cfg.svh ====
// Purpose: Offsets, field positions, reset values and cycle counts
// Assumes: Counts are in device clock cycles (nCK)
// Notes:   Included by both ends, the properties and the bench
`ifndef DDR_DLL_CFG_SVH
`define DDR_DLL_CFG_SVH
// Mode register selects on the bank address
`define MR0 3'h0
`define MR1 3'h1
`define MR2 3'h2
`define MR4 3'h4
`define MR5 3'h5
// Mode register field positions and values
`define DLL_EN_BIT  1'b1
`define DLL_EN_POS  0
`define DLL_RST_POS 8
`define SRA_POS     9
`define CRC_POS     12
`define BL8_FIXED   2'h0
`define CL_DLL_OFF  5'h0a
`define CWL_DLL_OFF 5'h09
`define CL_BASE     5'h09
`define CWL_BASE    5'h09
`define CL_CODE_10  4'h1
`define CWL_CODE_9  3'h0
// Wait counts in nCK
`define MOD_NCK      16'h0018
`define MRD_NCK      16'h0008
`define RFC_NCK      16'h0040
`define XS_NCK       16'h0050
`define XS_FAST_NCK  16'h0030
`define XS_ABORT_NCK 16'h0030
`define CKSRE_NCK    16'h000a
`define CKSRX_NCK    16'h000a
`define DLLK_NCK     16'h0400
`define SR_PERIOD    8'h40
`define SR_BUSY      8'h10
// Software register byte addresses
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_UCMD 8'h08
// Control register bits
`define C_GO_OFF 0
`define C_GO_ON  1
`define C_ODT_EN 2
`define C_SRA_EN 3
`define C_FAST   4
`endif

// ==== design/ddr_dll_pkg.sv ====
// Purpose: Shared types for the DLL switch ends
// Assumes: Constants live in ddr_dll_cfg.svh
// Notes:   Command codes are internal, not pin encodings
package ddr_dll_pkg;
  typedef enum logic [2:0] {
    CMD_DES  = 3'h0,
    CMD_MRS  = 3'h1,
    CMD_SRE  = 3'h2,
    CMD_SRX  = 3'h3,
    CMD_REF  = 3'h4,
    CMD_ZQCL = 3'h5,
    CMD_RD   = 3'h6,
    CMD_WR   = 3'h7
  } cmd_t;
  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_REF     = 4'h1,
    S_MR4     = 4'h2,
    S_MR1_OFF = 4'h3,
    S_SRE     = 4'h4,
    S_FREQ    = 4'h5,
    S_SRX     = 4'h6,
    S_MR0_CL  = 4'h7,
    S_MR2_CWL = 4'h8,
    S_MR1_ON  = 4'h9,
    S_MR0_RST = 4'ha,
    S_USER    = 4'hb
  } step_t;
endpackage

// ==== design/ddr_dll_if.sv ====
// Purpose: Command link between controller and memory device
// Assumes: One clock; device samples on rising edge
// Notes:   No clocking block
`timescale 1ns/10ps
`default_nettype none
interface ddr_dll_if
  import ddr_dll_pkg::*;
  (input wire logic clk);
  cmd_t        cmd;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic        cke;
  logic        odt;
  modport ctrl (input clk, output cmd, ba, addr, cke, odt);
  modport dev  (input clk, cmd, ba, addr, cke, odt);
endinterface
`default_nettype wire

// ==== design/wait_timer.sv ====
// Purpose: Down counter for command spacing
// Assumes: load_i wins over counting
// Notes:   done_o high once count_i edges have passed
`timescale 1ns/10ps
`default_nettype none
module wait_timer #(
  parameter int W = 16
) (
  input  wire logic         clk_i,   // Clock
  input  wire logic         rst_i,   // Sync reset
  input  wire logic         load_i,  // Start a wait
  input  wire logic [W-1:0] count_i, // Wait length
  output logic              done_o   // Wait over
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= '0;
    else if (load_i)
      cnt <= count_i;
    else if (cnt != '0)
      cnt <= cnt - 1'b1;
  end

  assign done_o = (cnt == '0);
endmodule
`default_nettype wire

// ==== design/ddr_dll_ctrl.sv ====
// Purpose: Controller end sequencing DLL on/off switches
// Assumes: Clock source obeys freq_req_o/clk_stable_i
// Notes:   One command step at a time, waits counted in nCK
`timescale 1ns/10ps
`default_nettype none
`include "ddr_dll_cfg.svh"
module ddr_dll_ctrl
  import ddr_dll_pkg::*;
#(
  parameter logic [15:0] MOD_NCK      = `MOD_NCK,
  parameter logic [15:0] MRD_NCK      = `MRD_NCK,
  parameter logic [15:0] RFC_NCK      = `RFC_NCK,
  parameter logic [15:0] XS_NCK       = `XS_NCK,
  parameter logic [15:0] XS_FAST_NCK  = `XS_FAST_NCK,
  parameter logic [15:0] XS_ABORT_NCK = `XS_ABORT_NCK,
  parameter logic [15:0] CKSRE_NCK    = `CKSRE_NCK,
  parameter logic [15:0] CKSRX_NCK    = `CKSRX_NCK,
  parameter logic [15:0] DLLK_NCK     = `DLLK_NCK
) (
  input  wire logic        clk_i,        // Clock
  input  wire logic        rst_i,        // Sync reset
  input  wire logic [7:0]  addr_i,       // Register address
  input  wire logic [31:0] wdata_i,      // Write data
  input  wire logic        wr_i,         // Write strobe
  input  wire logic        rd_i,         // Read strobe
  output logic      [31:0] rdata_o,      // Read data
  output logic             freq_req_o,   // Clock may change
  input  wire logic        clk_stable_i, // New clock stable
  ddr_dll_if.ctrl          mem           // Memory link
);
  step_t       step;
  logic        waiting;
  logic        dir_on;
  logic        need_ref;
  logic        err;
  logic        dll_on;
  logic        odt_en;
  logic        sra_en;
  logic        fast_en;
  logic        pend;
  cmd_t        u_cmd;
  logic [2:0]  u_ba;
  logic [13:0] u_addr;
  cmd_t        s_cmd;
  logic [2:0]  s_ba;
  logic [13:0] s_addr;
  logic [15:0] s_wait;
  step_t       s_next;
  logic        issue;
  logic        t_load;
  logic        t_done;
  logic        go_off;
  logic        go_on;
  logic        u_wr;
  logic        u_bad;
  localparam logic [3:0] CL_CODE = `CL_CODE_10;

  assign go_off = wr_i && addr_i == `REG_CTRL && wdata_i[`C_GO_OFF];
  assign go_on  = wr_i && addr_i == `REG_CTRL && wdata_i[`C_GO_ON];
  assign u_wr   = wr_i && addr_i == `REG_UCMD;
  assign issue  = !waiting && step != S_IDLE && step != S_FREQ;
  assign t_load = issue || (step == S_FREQ && !waiting && freq_req_o && clk_stable_i);

  // Refuse parity while DLL off, self refresh before a refresh, any while busy
  always_comb
  begin
    u_bad = 1'b0;
    if (step != S_IDLE || pend)
      u_bad = 1'b1;
    if (wdata_i[19:17] == CMD_MRS && wdata_i[16:14] == `MR5 && |wdata_i[2:0] && !dll_on)
      u_bad = 1'b1;
    if (wdata_i[19:17] == CMD_SRE && need_ref)
      u_bad = 1'b1;
  end

  // Command, address, wait and successor of each step
  always_comb
  begin
    s_cmd  = CMD_MRS;
    s_ba   = `MR0;
    s_addr = '0;
    s_wait = MOD_NCK;
    s_next = S_IDLE;
    unique case (step)
      S_IDLE:
      begin
        s_cmd = CMD_DES;
      end
      S_REF:
      begin
        s_cmd  = CMD_REF;
        s_wait = RFC_NCK;
        s_next = S_MR4;
      end
      S_MR4:
      begin
        s_ba   = `MR4;
        s_addr[`SRA_POS] = sra_en;
        s_next = dir_on ? S_SRE : S_MR1_OFF;
      end
      S_MR1_OFF:
      begin
        s_ba   = `MR1;
        s_addr[`DLL_EN_POS] = 1'b0;
        s_next = S_SRE;
      end
      S_SRE:
      begin
        s_cmd  = CMD_SRE;
        s_wait = CKSRE_NCK;
        s_next = S_FREQ;
      end
      S_FREQ:
      begin
        s_cmd  = CMD_DES;
        s_wait = CKSRX_NCK;
        s_next = S_SRX;
      end
      S_SRX:
      begin
        s_cmd  = CMD_SRX;
        if (sra_en)
          s_wait = XS_ABORT_NCK;
        else if (!dir_on && fast_en)
          s_wait = XS_FAST_NCK;
        else
          s_wait = XS_NCK;
        s_next = dir_on ? S_MR1_ON : S_MR0_CL;
      end
      S_MR0_CL:
      begin
        s_addr[2] = CL_CODE[0];
        s_addr[6:4] = CL_CODE[3:1];
        s_addr[1:0] = `BL8_FIXED;
        s_wait = MRD_NCK;
        s_next = S_MR2_CWL;
      end
      S_MR2_CWL:
      begin
        s_ba   = `MR2;
        s_addr[5:3] = `CWL_CODE_9;
        s_next = S_IDLE;
      end
      S_MR1_ON:
      begin
        s_ba   = `MR1;
        s_addr[`DLL_EN_POS] = `DLL_EN_BIT;
        s_wait = MRD_NCK;
        s_next = S_MR0_RST;
      end
      S_MR0_RST:
      begin
        s_addr[`DLL_RST_POS] = 1'b1;
        s_wait = DLLK_NCK;
      end
      S_USER:
      begin
        s_cmd  = u_cmd;
        s_ba   = u_ba;
        s_addr = u_addr;
        if (u_cmd == CMD_REF)
          s_wait = RFC_NCK;
        else if (u_cmd == CMD_SRX)
          s_wait = XS_NCK;
        else if (u_cmd != CMD_MRS)
          s_wait = 16'h0001;
      end
    endcase
  end

  wait_timer #(.W(16)) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (t_load),
    .count_i (s_wait),
    .done_o  (t_done)
  );

  // Step sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      step    <= S_IDLE;
      waiting <= 1'b0;
      dir_on  <= 1'b0;
    end
    else if (step == S_IDLE)
    begin
      if (go_off || go_on)
      begin
        dir_on <= go_on;
        step   <= need_ref ? S_REF : S_MR4;
      end
      else if (pend)
        step <= S_USER;
    end
    else if (t_load)
      waiting <= 1'b1;
    else if (waiting && t_done)
    begin
      waiting <= 1'b0;
      step    <= s_next;
    end
  end

  // Link outputs; deselect whenever no step issues
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mem.cmd  <= CMD_DES;
      mem.ba   <= 3'h0;
      mem.addr <= 14'h0000;
    end
    else
    begin
      mem.cmd  <= issue ? s_cmd : CMD_DES;
      mem.ba   <= issue ? s_ba : 3'h0;
      mem.addr <= issue ? s_addr : 14'h0000;
    end
  end

  // CKE low only inside self refresh
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mem.cke <= 1'b1;
    else if (issue && s_cmd == CMD_SRE)
      mem.cke <= 1'b0;
    else if (issue && s_cmd == CMD_SRX)
      mem.cke <= 1'b1;
  end

  // ODT held low through every step other than S_IDLE
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mem.odt <= 1'b0;
    else
      mem.odt <= odt_en && step == S_IDLE && !go_off && !go_on && !pend;
  end

  // Clock change window between tCKSRE and the stable clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      freq_req_o <= 1'b0;
    else if (step == S_FREQ && !waiting && !clk_stable_i)
      freq_req_o <= 1'b1;
    else if (t_load)
      freq_req_o <= 1'b0;
  end

  // Refresh owed after any self refresh exit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      need_ref <= 1'b0;
    else if (issue && s_cmd == CMD_SRX)
      need_ref <= 1'b1;
    else if (issue && s_cmd == CMD_REF)
      need_ref <= 1'b0;
  end

  // Tracked DLL state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dll_on <= 1'b1;
    else if (issue && s_cmd == CMD_MRS && s_ba == `MR1)
      dll_on <= s_addr[`DLL_EN_POS];
  end

  // Control bits and queued user command
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      odt_en  <= 1'b0;
      sra_en  <= 1'b0;
      fast_en <= 1'b0;
      pend    <= 1'b0;
      err     <= 1'b0;
      u_cmd   <= CMD_DES;
      u_ba    <= 3'h0;
      u_addr  <= 14'h0000;
    end
    else
    begin
      if (wr_i && addr_i == `REG_CTRL)
      begin
        odt_en  <= wdata_i[`C_ODT_EN];
        sra_en  <= wdata_i[`C_SRA_EN];
        fast_en <= wdata_i[`C_FAST];
      end
      if (u_wr && !u_bad)
      begin
        pend   <= 1'b1;
        u_cmd  <= cmd_t'(wdata_i[19:17]);
        u_ba   <= wdata_i[16:14];
        u_addr <= wdata_i[13:0];
      end
      else if (step == S_USER)
        pend <= 1'b0;
      if (u_wr && u_bad)
        err <= 1'b1;
      else if (rd_i && addr_i == `REG_STAT)
        err <= 1'b0;
    end
  end

  // Register read port
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= 32'h0000_0000;
    else if (rd_i && addr_i == `REG_CTRL)
      rdata_o <= {27'h0, fast_en, sra_en, odt_en, 2'h0};
    else if (rd_i && addr_i == `REG_STAT)
      rdata_o <= {22'h0, step, pend, need_ref, dll_on, err, step != S_IDLE, freq_req_o};
    else
      rdata_o <= 32'h0000_0000;
  end
endmodule
`default_nettype wire

// ==== design/ddr_dll_dev.sv ====
// Purpose: Device end: mode registers, DLL, refresh, read strobe
// Assumes: Controller keeps the switching sequence
// Notes:   One read in flight at a time
`timescale 1ns/10ps
`default_nettype none
`include "ddr_dll_cfg.svh"
module ddr_dll_dev
  import ddr_dll_pkg::*;
#(
  parameter logic [15:0] DLLK_NCK  = `DLLK_NCK,
  parameter logic [7:0]  SR_PERIOD = `SR_PERIOD,
  parameter logic [7:0]  SR_BUSY   = `SR_BUSY
) (
  input  wire logic        clk_i,        // Clock
  input  wire logic        rst_i,        // Sync reset
  ddr_dll_if.dev           mem,          // Memory link
  output logic             dll_on_o,     // DLL enabled
  output logic             dll_locked_o, // DLL locked
  output logic             in_sr_o,      // In self refresh
  output logic      [15:0] ref_count_o,  // Refresh counter
  output logic             rdqs_o,       // Read strobe start pulse
  output logic      [2:0]  wr_col_o,     // Write burst start column
  output logic             wr_col_vld_o, // Write column valid pulse
  output logic             lat_ok_o,     // Latencies supported
  output logic             parity_on_o   // CA parity enabled
);
  logic [3:0] cl_code;
  logic [1:0] bl;
  logic [1:0] al_code;
  logic [2:0] cwl_code;
  logic       sra_en;
  logic       crc_en;
  logic [7:0] sr_cnt;
  logic       locking;
  logic       t_done;
  logic [5:0] rd_cnt;
  logic       rd_act;
  logic [5:0] cl;
  logic [5:0] al;
  logic       is_mrs;
  logic       dll_rst;

  assign is_mrs  = mem.cmd == CMD_MRS;
  assign dll_rst = is_mrs && mem.ba == `MR0 && mem.addr[`DLL_RST_POS] && dll_on_o;
  assign cl = 6'(`CL_BASE) + 6'({cl_code[3:1], cl_code[0]});
  assign al = (al_code == 2'h1) ? cl - 6'h01 : (al_code == 2'h2) ? cl - 6'h02 : 6'h00;

  // Mode register fields
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dll_on_o    <= 1'b1;
      cl_code     <= `CL_CODE_10;
      bl          <= `BL8_FIXED;
      al_code     <= 2'h0;
      cwl_code    <= `CWL_CODE_9;
      sra_en      <= 1'b0;
      crc_en      <= 1'b0;
      parity_on_o <= 1'b0;
    end
    else if (is_mrs)
    begin
      unique case (mem.ba)
        `MR0:
        begin
          bl      <= mem.addr[1:0];
          cl_code <= {mem.addr[6:4], mem.addr[2]};
        end
        `MR1:
        begin
          dll_on_o <= mem.addr[`DLL_EN_POS];
          al_code  <= mem.addr[4:3];
        end
        `MR2:
        begin
          cwl_code <= mem.addr[5:3];
          crc_en   <= mem.addr[`CRC_POS];
        end
        `MR4:
          sra_en <= mem.addr[`SRA_POS];
        `MR5:
          parity_on_o <= |mem.addr[2:0];
        default:
          sra_en <= sra_en;
      endcase
    end
  end

  // DLL-off mode supports one latency pair only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lat_ok_o <= 1'b1;
    else
      lat_ok_o <= dll_on_o || (cl_code == `CL_CODE_10 && cwl_code == `CWL_CODE_9);
  end

  wait_timer #(.W(16)) u_lock (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (dll_rst),
    .count_i (DLLK_NCK),
    .done_o  (t_done)
  );

  // DLL lock after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      locking      <= 1'b0;
      dll_locked_o <= 1'b1;
    end
    else if (dll_rst)
    begin
      locking      <= 1'b1;
      dll_locked_o <= 1'b0;
    end
    else if (!dll_on_o)
      dll_locked_o <= 1'b0;
    else if (locking && t_done)
    begin
      locking      <= 1'b0;
      dll_locked_o <= 1'b1;
    end
  end

  // Self refresh with internal refresh bursts
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_sr_o     <= 1'b0;
      sr_cnt      <= 8'h00;
      ref_count_o <= 16'h0000;
    end
    else if (mem.cmd == CMD_SRE && !mem.cke)
    begin
      in_sr_o <= 1'b1;
      sr_cnt  <= 8'h00;
    end
    else if (in_sr_o && mem.cmd == CMD_SRX && mem.cke)
    begin
      in_sr_o <= 1'b0;
      if (sr_cnt != 8'h00 && !sra_en)
        ref_count_o <= ref_count_o + 16'h0001;
    end
    else if (in_sr_o)
    begin
      sr_cnt <= (sr_cnt == SR_PERIOD - 8'h01) ? 8'h00 : sr_cnt + 8'h01;
      if (sr_cnt == SR_BUSY)
        ref_count_o <= ref_count_o + 16'h0001;
    end
    else if (mem.cmd == CMD_REF)
      ref_count_o <= ref_count_o + 16'h0001;
  end

  // Read strobe reference, one clock earlier with DLL off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_act <= 1'b0;
      rd_cnt <= 6'h00;
      rdqs_o <= 1'b0;
    end
    else
    begin
      rdqs_o <= rd_act && rd_cnt == 6'h00;
      if (mem.cmd == CMD_RD)
      begin
        rd_act <= 1'b1;
        rd_cnt <= al + cl - (dll_on_o ? 6'h01 : 6'h02);
      end
      else if (rd_act && rd_cnt == 6'h00)
        rd_act <= 1'b0;
      else if (rd_act)
        rd_cnt <= rd_cnt - 6'h01;
    end
  end

  // Write burst start column
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_col_o     <= 3'h0;
      wr_col_vld_o <= 1'b0;
    end
    else
    begin
      wr_col_vld_o <= mem.cmd == CMD_WR;
      if (mem.cmd == CMD_WR)
        wr_col_o <= (crc_en && bl == `BL8_FIXED) ? 3'h0 : mem.addr[2:0];
    end
  end
endmodule
`default_nettype wire

// ==== verification/ddr_dll_switch_properties.sv ====
// Purpose: Link-side properties of the DLL switch sequences
// Assumes: Sees only the command link; counts in nCK
// Notes:   Instantiated beside the link, no bind
`timescale 1ns/10ps
`default_nettype none
`include "ddr_dll_cfg.svh"
module ddr_dll_switch_properties
  import ddr_dll_pkg::*;
#(
  parameter logic [15:0] MOD_NCK      = `MOD_NCK,
  parameter logic [15:0] XS_NCK       = `XS_NCK,
  parameter logic [15:0] XS_FAST_NCK  = `XS_FAST_NCK,
  parameter logic [15:0] XS_ABORT_NCK = `XS_ABORT_NCK,
  parameter logic [15:0] CKSRE_NCK    = `CKSRE_NCK,
  parameter logic [15:0] CKSRX_NCK    = `CKSRX_NCK,
  parameter logic [15:0] DLLK_NCK     = `DLLK_NCK
) (
  input wire logic        clk,   // Link clock
  input wire logic        rst_i, // Sync reset
  input wire cmd_t        cmd,   // Command
  input wire logic [2:0]  ba,    // Register select
  input wire logic [13:0] addr,  // Value or column
  input wire logic        cke,   // Clock enable
  input wire logic        odt    // Termination
);
  logic [15:0] since_mrs;
  logic [15:0] since_sre;
  logic [15:0] since_srx;
  logic [15:0] since_rst;
  logic        owed;
  logic        sra;
  logic        dll_off;
  logic        rst_mrs;
  assign rst_mrs = cmd == CMD_MRS && ba == `MR0 && addr[`DLL_RST_POS];

  function automatic logic [15:0] sat(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  // Cycles since the last MRS, SRE, SRX and DLL reset MRS
  always_ff @(posedge clk)
  begin
    if (rst_i)
    begin
      since_mrs <= 16'hffff;
      since_sre <= 16'hffff;
      since_srx <= 16'hffff;
      since_rst <= 16'hffff;
    end
    else
    begin
      since_mrs <= (cmd == CMD_MRS) ? 16'h0000 : sat(since_mrs);
      since_sre <= (cmd == CMD_SRE) ? 16'h0000 : sat(since_sre);
      since_srx <= (cmd == CMD_SRX) ? 16'h0000 : sat(since_srx);
      since_rst <= rst_mrs ? 16'h0000 : sat(since_rst);
    end
  end

  // Refresh owed, abort setting and DLL mode as last written
  always_ff @(posedge clk)
  begin
    if (rst_i)
    begin
      owed <= 1'b0;
      sra <= 1'b0;
      dll_off <= 1'b0;
    end
    else
    begin
      if (cmd == CMD_SRX)
        owed <= 1'b1;
      else if (cmd == CMD_REF)
        owed <= 1'b0;
      if (cmd == CMD_MRS && ba == `MR4)
        sra <= addr[`SRA_POS];
      if (cmd == CMD_MRS && ba == `MR1)
        dll_off <= !addr[`DLL_EN_POS];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst_i);

  sequence mrs_s;
    cmd == CMD_MRS;
  endsequence
  sequence dll_reset_s;
    rst_mrs && !dll_off;
  endsequence
  sequence quiet_hold_s;
    (cke && !odt && cmd == CMD_DES) [*8];
  endsequence

  mrs_gap_a:
    assert property (mrs_s |=> (cmd == CMD_DES) [*8]) else $error("command too soon after MRS");
  odt_off_a:
    assert property (mrs_s and (ba == `MR1 && !addr[0]) |-> !odt && cke) else $error("ODT on");
  sr_entry_a:
    assert property (cmd == CMD_SRE |-> !cke && since_mrs > MOD_NCK) else $error("early SRE");
  sr_exit_a:
    assert property (cmd == CMD_SRX |-> cke && $past(cke) == 1'b0
      && since_sre > CKSRE_NCK + CKSRX_NCK) else $error("early SRX");
  exit_hold_a:
    assert property (cmd == CMD_SRX |=> quiet_hold_s) else $error("CKE or ODT after SRX");
  fast_exit_a:
    assert property (cmd != CMD_DES && cmd != CMD_SRX
      |-> since_srx > (sra ? XS_ABORT_NCK : XS_FAST_NCK)) else $error("within fast exit");
  xs_wait_a:
    assert property ((cmd == CMD_MRS && ba == `MR1) || cmd inside {CMD_REF, CMD_RD, CMD_WR}
      |-> since_srx > (sra ? XS_ABORT_NCK : XS_NCK)) else $error("within exit time");
  refresh_owed_a:
    assert property (cmd == CMD_SRE |-> !owed) else $error("SRE with refresh owed");
  mod_done_a:
    assert property (cmd inside {CMD_REF, CMD_ZQCL, CMD_RD, CMD_WR} |-> since_mrs > MOD_NCK)
      else $error("command within MOD");
  dll_lock_a:
    assert property (dll_reset_s |=> quiet_hold_s) else $error("CKE or ODT in relock");
  locked_cmd_a:
    assert property (cmd inside {CMD_RD, CMD_WR} |-> since_rst > DLLK_NCK)
      else $error("access before lock");
  parity_off_a:
    assert property (mrs_s and (ba == `MR5 && dll_off) |-> addr[2:0] == 3'h0)
      else $error("parity in DLL-off");
endmodule
`default_nettype wire

// ==== verification/ddr_dll_mode_switch_tb.sv ====
// Purpose: Self-checking bench for the DLL on/off switch
// Assumes: Both ends joined by the command link
// Notes:   Small DLLK keeps the run short
`timescale 1ns/10ps
`default_nettype none
`include "ddr_dll_cfg.svh"
module ddr_dll_mode_switch_tb
  import ddr_dll_pkg::*;
;
  localparam logic [15:0] DLLK = 16'h0020;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        clk_stable_i = 1'b0;
  logic [31:0] rdata_o;
  logic        freq_req_o;
  logic        dll_on_o;
  logic        dll_locked_o;
  logic        in_sr_o;
  logic [15:0] ref_count_o;
  logic        rdqs_o;
  logic [2:0]  wr_col_o;
  logic        wr_col_vld_o;
  logic        lat_ok_o;
  logic        parity_on_o;
  logic [31:0] seed = 32'h603a;
  logic [31:0] stab_wait = 32'h0;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          exp_cl = 10;
  int          exp_on = 1;
  logic        exp_crc = 1'b0;
  int          rd_q[$];
  logic [2:0]  col_q[$];

  always #2 clk_i = ~clk_i;

  ddr_dll_if u_ddr_dll_if (.clk(clk_i));
  ddr_dll_ctrl #(.DLLK_NCK(DLLK)) u_ddr_dll_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .freq_req_o(freq_req_o), .clk_stable_i(clk_stable_i), .mem(u_ddr_dll_if.ctrl));
  ddr_dll_dev #(.DLLK_NCK(DLLK)) u_ddr_dll_dev (.clk_i(clk_i), .rst_i(rst_i),
    .mem(u_ddr_dll_if.dev), .dll_on_o(dll_on_o), .dll_locked_o(dll_locked_o),
    .in_sr_o(in_sr_o), .ref_count_o(ref_count_o), .rdqs_o(rdqs_o), .wr_col_o(wr_col_o),
    .wr_col_vld_o(wr_col_vld_o), .lat_ok_o(lat_ok_o), .parity_on_o(parity_on_o));
  ddr_dll_switch_properties #(.DLLK_NCK(DLLK)) u_props (.clk(u_ddr_dll_if.clk),
    .rst_i(rst_i), .cmd(u_ddr_dll_if.cmd), .ba(u_ddr_dll_if.ba), .addr(u_ddr_dll_if.addr),
    .cke(u_ddr_dll_if.cke), .odt(u_ddr_dll_if.odt));

  function automatic logic [31:0] xrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic ucmd(input cmd_t c, input logic [2:0] b, input logic [13:0] a);
    wr_reg(`REG_UCMD, {12'h0, c, b, a});
    repeat (40) @(posedge clk_i);
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    int n;
    n = 0;
    s = 32'h2;
    while (s[1] !== 1'b0 && n < 500)
    begin
      rd_reg(`REG_STAT, s);
      n++;
    end
    check(s & 32'h3c2, 32'h0);
  endtask

  // Model of read strobe timing and write start column
  always @(posedge clk_i)
  begin
    cyc++;
    if (u_ddr_dll_if.cmd === CMD_RD)
      rd_q.push_back(cyc + exp_cl + exp_on);
    if (u_ddr_dll_if.cmd === CMD_WR)
      col_q.push_back(exp_crc ? 3'h0 : u_ddr_dll_if.addr[2:0]);
    if (rdqs_o === 1'b1)
      check(32'(cyc), 32'(rd_q.size() > 0 ? rd_q.pop_front() : 0));
    if (wr_col_vld_o === 1'b1)
      check({29'h0, wr_col_o}, {29'h0, col_q.size() > 0 ? col_q.pop_front() : 3'h7});
  end

  // New clock settles a random time after the request
  always @(posedge clk_i)
    if (freq_req_o !== 1'b1)
    begin
      clk_stable_i <= 1'b0;
      stab_wait <= xrand() & 32'hf;
    end
    else if (stab_wait == 32'h0)
      clk_stable_i <= 1'b1;
    else
      stab_wait <= stab_wait - 32'h1;

  initial
  begin
    logic [31:0] s;
    logic [31:0] r;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check({24'h0, u_ddr_dll_if.cke, u_ddr_dll_if.odt, dll_on_o, dll_locked_o, lat_ok_o,
      parity_on_o, freq_req_o, in_sr_o}, 32'h000000b8);
    check({16'h0, ref_count_o}, 32'h0);
    wr_reg(`REG_CTRL, 32'h00000014);
    wr_reg(8'h10, 32'hffffffff);
    rd_reg(`REG_CTRL, s);
    check(s & 32'h1c, 32'h14);
    rd_reg(8'h0c, s);
    check(s, 32'h0);
    check({31'h0, u_ddr_dll_if.odt}, 32'h1);
    exp_on = 0;
    wr_reg(`REG_CTRL, 32'h00000015);
    wait_idle();
    check({29'h0, dll_on_o, dll_locked_o, lat_ok_o}, 32'h1);
    check({16'h0, ref_count_o}, 32'h2);
    rd_reg(`REG_STAT, s);
    check(s & 32'h18, 32'h10);
    r = xrand();
    ucmd(CMD_RD, 3'h0, r[13:0]);
    ucmd(CMD_MRS, `MR0, 14'h0000);
    check({31'h0, lat_ok_o}, 32'h0);
    exp_crc = 1'b1;
    ucmd(CMD_MRS, `MR2, 14'h1000);
    r = xrand();
    ucmd(CMD_WR, 3'h0, r[13:0] | 14'h0005);
    exp_crc = 1'b0;
    ucmd(CMD_MRS, `MR2, 14'h0000);
    r = xrand();
    ucmd(CMD_WR, 3'h0, r[13:0] | 14'h0003);
    ucmd(CMD_MRS, `MR5, 14'h0001);
    rd_reg(`REG_STAT, s);
    check({30'h0, s[2], parity_on_o}, 32'h2);
    ucmd(CMD_SRE, 3'h0, 14'h0000);
    rd_reg(`REG_STAT, s);
    check({30'h0, s[2], in_sr_o}, 32'h2);
    rd_reg(`REG_STAT, s);
    check(s & 32'h4, 32'h0);
    exp_on = 1;
    wr_reg(`REG_CTRL, 32'h0000000e);
    wait_idle();
    check({30'h0, dll_on_o, dll_locked_o}, 32'h3);
    check({16'h0, ref_count_o}, 32'h4);
    r = xrand();
    exp_cl = 9 + int'(r[2:0]);
    ucmd(CMD_MRS, `MR0, {8'h0, r[2:1], 1'b0, r[0], 2'h0});
    ucmd(CMD_RD, 3'h0, r[17:4]);
    check(32'(rd_q.size() + col_q.size()), 32'h0);
    end_of_test();
  end

  initial
  begin
    #80000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
